// file: hdl/dpt_pkg.sv
// dual programmable timer: register map, field layout, types and timing constants
// assumes a 32-bit classic wishbone slave port and a 10 MHz system clock
package dpt_pkg;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] DPT_ADR_CTRL = 8'h00;
   localparam logic [7:0] DPT_ADR_T0CFG = 8'h04;
   localparam logic [7:0] DPT_ADR_T1CFG = 8'h08;
   localparam logic [7:0] DPT_ADR_RELOAD0 = 8'h0c;
   localparam logic [7:0] DPT_ADR_RELOAD1 = 8'h10;
   localparam logic [7:0] DPT_ADR_COUNT = 8'h14;
   localparam logic [7:0] DPT_ADR_IRQ_FLAG = 8'h18;
   localparam logic [7:0] DPT_ADR_IRQ_EN = 8'h1c;
   localparam logic [7:0] DPT_ADR_PRIO = 8'h20;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int DPT_CTRL_W = 5;
   localparam int DPT_T0CFG_W = 8;
   localparam int DPT_T1CFG_W = 5;
   localparam int DPT_PRESET_BIT = 1;
   localparam int DPT_IRQ0_BIT = 0;
   localparam int DPT_IRQ1_BIT = 1;

   // ---------------------------------------------------------------
   // prescaler ratio codes and divisors
   // ---------------------------------------------------------------
   localparam logic [1:0] DPT_RATIO_1 = 2'h0;
   localparam logic [1:0] DPT_RATIO_4 = 2'h1;
   localparam logic [1:0] DPT_RATIO_16 = 2'h2;
   localparam logic [6:0] DPT_DIV_4 = 7'h04;
   localparam logic [6:0] DPT_DIV_16 = 7'h10;
   localparam logic [6:0] DPT_DIV_64 = 7'h40;

   // ---------------------------------------------------------------
   // interrupt vectors and noise rejecter timing
   // ---------------------------------------------------------------
   localparam logic [23:0] DPT_VEC_T1 = 24'h000006;
   localparam logic [23:0] DPT_VEC_T0 = 24'h000008;
   localparam int DPT_NR_CLK_HZ = 2048;
   localparam int DPT_LO_OSC_HZ = 32768;
   localparam int DPT_NR_DIV = DPT_LO_OSC_HZ / DPT_NR_CLK_HZ;
   localparam logic [1:0] DPT_NR_EDGES = 2'h2;

   // ---------------------------------------------------------------
   // control words
   // ---------------------------------------------------------------
   typedef struct packed {
      logic cascade_select;
      logic output_channel_select;
      logic output_enable;
      logic timer1_source_select;
      logic timer0_source_select;
   } dpt_ctrl_s;

   typedef struct packed {
      logic counter_mode_select;
      logic function_select;
      logic input_polarity;
      logic [1:0] ratio;
      logic continuous;
      logic preset;
      logic run;
   } dpt_t0cfg_s;

   typedef struct packed {
      logic [1:0] ratio;
      logic continuous;
      logic preset;
      logic run;
   } dpt_t1cfg_s;

endpackage

// file: hdl/dpt_prescaler.sv
// prescaler: divides a source tick stream by 1, 4, 16 or 64 while running
// assumes src_tick_i is a one-cycle pulse on clk_i
module dpt_prescaler (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic run_i,
   input wire logic [1:0] ratio_i,
   // ticks
   input wire logic src_tick_i,
   output logic tick_o
);
   import dpt_pkg::*;

   logic [6:0] cnt_ff;
   logic [6:0] nxt_cnt;
   logic [6:0] div;
   logic gated;

   function automatic logic [6:0] ratio_div(input logic [1:0] r);
      if (r == DPT_RATIO_4) begin
         return DPT_DIV_4;
      end else if (r == DPT_RATIO_16) begin
         return DPT_DIV_16;
      end else begin
         return DPT_DIV_64;
      end
   endfunction

   // source reaches the divider only while running
   assign gated = src_tick_i & run_i;
   assign div = ratio_div(ratio_i);

   always_comb begin
      nxt_cnt = cnt_ff;
      if (gated) begin
         nxt_cnt = (cnt_ff == div - 7'h01) ? 7'h00 : cnt_ff + 7'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || ratio_i == DPT_RATIO_1) begin
         cnt_ff <= 7'h00;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // undivided ratio passes the source straight through
   assign tick_o = (ratio_i == DPT_RATIO_1) ? gated : (gated && cnt_ff == div - 7'h01); // R3 R4
endmodule

// file: hdl/dpt_timer.sv
// dual 8-bit programmable down timer, cascadable to 16 bits, wishbone register port
// assumes oscillator and event inputs are asynchronous pins; one system clock
// Functional notes
// R1: source select 0 picks low-speed oscillator, 1 picks high-speed oscillator.
// R2: in cascade mode only timer 0 source select chooses the clock.
// R3: ratio 11 divides by 64, 10 by 16, 01 by 4, 00 by 1.
// R4: run bit gates source into prescaler so divided clock decrements counter.
// R5: in cascade mode only timer 0 ratio sets division.
// R6: timer mode decrements on each prescaler pulse.
// R7: counter mode counts event input on timer 0; cascade gives 16-bit counter.
// R8: event counter mode ignores timer 0 prescaler ratio.
// R9: polarity 0 counts falling edges, 1 counts rising edges.
// R10: noise rejecter counts at second 2048 Hz falling edge after level change.
// R11: event source must hold each level at least 0.98 ms with rejecter.
// R12: function select in timer mode measures pulse width on timer 0.
// R13: polarity 0 measures low width, 1 measures high width.
// R14: underflow sets flag; request only when its enable is set.
// R15: interrupt priority level 0 to 3 from a two-bit field.
// R16: timer 1 vector 000006h, timer 0 vector 000008h.
// R17: cascade mode never sets timer 0 flag; 16-bit underflow sets timer 1 flag.
// R18: timer output toggles on each selected underflow.
// R19: channel select 0 timer 0, 1 timer 1; cascade always combined counter.
// R20: output enable 1 drives timer output on pin, 0 drives pin high.
// R21: software keeps port data bit at 1 while timer output is routed.
// R22: output enable gates timer output asynchronously, glitch possible.
// R23: writing preset 1 loads counter from reload value.
// R24: underflow reloads; one-shot stops and clears run, continuous keeps counting.
// R25: cascade mode: timer 0 low byte, timer 1 high byte, timer 0 controls.
// R26: stopping preserves counter contents; later run resumes.
// R27: event input synchronized before edge or level detection.
// R28: timer 1 underflow serves as serial bit clock, reload mode required.
module dpt_timer #(
   parameter int CNT_W = 8,
   parameter int NR_DIV = dpt_pkg::DPT_NR_DIV
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // oscillators and event pin
   input wire logic low_speed_oscillator_i,
   input wire logic high_speed_oscillator_i,
   input wire logic event_input_pin_i,
   // interrupt requests to the processor
   output logic timer0_irq_o,
   output logic timer1_irq_o,
   output logic [1:0] irq_priority_o,
   output logic [23:0] irq_vector_o,
   // serial clock and output pin
   output logic serial_clock_tick_o,
   output logic divided_underflow_output_o,
   output logic output_port_pin_o
);
   import dpt_pkg::*;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   dpt_ctrl_s ctrl_ff;
   dpt_t0cfg_s t0cfg_ff;
   dpt_t1cfg_s t1cfg_ff;
   logic [CNT_W-1:0] reload0_ff, reload1_ff, cnt0_ff, cnt1_ff;
   logic [1:0] flag_ff, irq_en_ff, prio_ff;
   logic ack_ff;
   logic [31:0] dat_ff;
   logic divided_underflow_output_ff;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic req, wr, wr_lo;
   assign req = cyc_i & stb_i & ~ack_ff;
   assign wr = cyc_i & stb_i & we_i & ack_ff;
   assign wr_lo = wr & sel_i[0];

   logic wr_ctrl, wr_t0, wr_t1, wr_rl0, wr_rl1, wr_flag, wr_en, wr_prio;
   always_comb begin
      wr_ctrl = 1'b0;
      wr_t0 = 1'b0;
      wr_t1 = 1'b0;
      wr_rl0 = 1'b0;
      wr_rl1 = 1'b0;
      wr_flag = 1'b0;
      wr_en = 1'b0;
      wr_prio = 1'b0;
      if (adr_i == DPT_ADR_CTRL) begin
         wr_ctrl = wr_lo;
      end else if (adr_i == DPT_ADR_T0CFG) begin
         wr_t0 = wr_lo;
      end else if (adr_i == DPT_ADR_T1CFG) begin
         wr_t1 = wr_lo;
      end else if (adr_i == DPT_ADR_RELOAD0) begin
         wr_rl0 = wr_lo;
      end else if (adr_i == DPT_ADR_RELOAD1) begin
         wr_rl1 = wr_lo;
      end else if (adr_i == DPT_ADR_IRQ_FLAG) begin
         wr_flag = wr_lo;
      end else if (adr_i == DPT_ADR_IRQ_EN) begin
         wr_en = wr_lo;
      end else if (adr_i == DPT_ADR_PRIO) begin
         wr_prio = wr_lo;
      end
   end

   // ---------------------------------------------------------------
   // synchronisers
   // ---------------------------------------------------------------
   logic [1:0] lo_sync_ff, hi_sync_ff, evt_sync_ff;
   logic lo_prev_ff, hi_prev_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lo_sync_ff <= 2'h0;
         hi_sync_ff <= 2'h0;
         evt_sync_ff <= 2'h0;
         lo_prev_ff <= 1'b0;
         hi_prev_ff <= 1'b0;
      end else begin
         lo_sync_ff <= {lo_sync_ff[0], low_speed_oscillator_i};
         hi_sync_ff <= {hi_sync_ff[0], high_speed_oscillator_i};
         evt_sync_ff <= {evt_sync_ff[0], event_input_pin_i}; // R27
         lo_prev_ff <= lo_sync_ff[1];
         hi_prev_ff <= hi_sync_ff[1];
      end
   end

   logic lo_tick, hi_tick;
   assign lo_tick = lo_sync_ff[1] & ~lo_prev_ff;
   assign hi_tick = hi_sync_ff[1] & ~hi_prev_ff;

   // ---------------------------------------------------------------
   // noise rejecter
   // ---------------------------------------------------------------
   logic [$clog2(NR_DIV)-1:0] nr_div_ff;
   logic nr_tick;
   logic [1:0] nr_cnt_ff;
   logic nr_lvl_ff;
   logic evt_lvl, evt_prev_ff;

   // one pulse per falling edge of the 2048 Hz reference
   assign nr_tick = lo_tick && nr_div_ff == '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nr_div_ff <= '0;
      end else if (lo_tick) begin
         nr_div_ff <= (nr_div_ff == $bits(nr_div_ff)'(NR_DIV - 1)) ? '0 : nr_div_ff + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nr_cnt_ff <= 2'h0;
         nr_lvl_ff <= 1'b0;
      end else if (evt_sync_ff[1] == nr_lvl_ff) begin
         nr_cnt_ff <= 2'h0;
      end else if (nr_tick) begin
         if (nr_cnt_ff + 2'h1 == DPT_NR_EDGES) begin
            nr_lvl_ff <= evt_sync_ff[1]; // R10
            nr_cnt_ff <= 2'h0;
         end else begin
            nr_cnt_ff <= nr_cnt_ff + 2'h1;
         end
      end
   end

   assign evt_lvl = (t0cfg_ff.counter_mode_select && t0cfg_ff.function_select) ?
                    nr_lvl_ff : evt_sync_ff[1];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         evt_prev_ff <= 1'b0;
      end else begin
         evt_prev_ff <= evt_lvl;
      end
   end

   logic evt_edge;
   assign evt_edge = t0cfg_ff.input_polarity ? (evt_lvl & ~evt_prev_ff) :
                     (~evt_lvl & evt_prev_ff); // R9

   // ---------------------------------------------------------------
   // prescalers and count enables
   // ---------------------------------------------------------------
   logic casc, pre0_tick, pre1_tick, src0, src1, run1;
   assign casc = ctrl_ff.cascade_select;
   assign run1 = t1cfg_ff.run & ~casc; // R25
   assign src0 = ctrl_ff.timer0_source_select ? hi_tick : lo_tick; // R1 R2
   assign src1 = ctrl_ff.timer1_source_select ? hi_tick : lo_tick; // R1

   dpt_prescaler u_pre0 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(t0cfg_ff.run & ~t0cfg_ff.counter_mode_select),
      .ratio_i(t0cfg_ff.ratio), // R5 R8
      .src_tick_i(src0),
      .tick_o(pre0_tick)
   );

   dpt_prescaler u_pre1 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(run1),
      .ratio_i(t1cfg_ff.ratio),
      .src_tick_i(src1),
      .tick_o(pre1_tick)
   );

   logic tick0, tick1, pw_gate;
   assign pw_gate = (evt_sync_ff[1] == t0cfg_ff.input_polarity); // R13
   always_comb begin
      if (t0cfg_ff.counter_mode_select) begin
         tick0 = evt_edge & t0cfg_ff.run; // R7 R8
      end else if (t0cfg_ff.function_select) begin
         tick0 = pre0_tick & pw_gate; // R12
      end else begin
         tick0 = pre0_tick; // R6
      end
   end
   assign tick1 = pre1_tick;

   // ---------------------------------------------------------------
   // down counters
   // ---------------------------------------------------------------
   logic uf0, uf1, uf16, zero0, zero1;
   assign zero0 = (cnt0_ff == '0);
   assign zero1 = (cnt1_ff == '0);
   assign uf16 = casc & tick0 & zero0 & zero1;
   assign uf0 = ~casc & tick0 & zero0;
   assign uf1 = (~casc & tick1 & zero1) | uf16;

   logic preset0, preset1;
   assign preset0 = wr_t0 & dat_i[DPT_PRESET_BIT];
   assign preset1 = wr_t1 & dat_i[DPT_PRESET_BIT] & ~casc;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt0_ff <= '0;
      end else if (preset0 || (tick0 && zero0 && (!casc || zero1))) begin
         cnt0_ff <= reload0_ff; // R23 R24
      end else if (tick0) begin
         cnt0_ff <= cnt0_ff - 1'b1; // R26
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt1_ff <= '0;
      end else if (preset1 || (casc && preset0) || (uf1 && (casc || tick1))) begin
         cnt1_ff <= reload1_ff; // R23 R24
      end else if (casc ? (tick0 && zero0) : tick1) begin
         cnt1_ff <= cnt1_ff - 1'b1; // R25
      end
   end

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= '0;
      end else if (wr_ctrl) begin
         ctrl_ff <= dpt_ctrl_s'(dat_i[DPT_CTRL_W-1:0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t0cfg_ff <= '0;
      end else if (wr_t0) begin
         t0cfg_ff <= dpt_t0cfg_s'(dat_i[DPT_T0CFG_W-1:0]);
         t0cfg_ff.preset <= 1'b0;
      end else if ((uf0 || uf16) && !t0cfg_ff.continuous) begin
         t0cfg_ff.run <= 1'b0; // R24
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t1cfg_ff <= '0;
      end else if (wr_t1) begin
         t1cfg_ff <= dpt_t1cfg_s'(dat_i[DPT_T1CFG_W-1:0]);
         t1cfg_ff.preset <= 1'b0;
      end else if (uf1 && !casc && !t1cfg_ff.continuous) begin
         t1cfg_ff.run <= 1'b0; // R24
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload0_ff <= '0;
         reload1_ff <= '0;
         irq_en_ff <= 2'h0;
         prio_ff <= 2'h0;
      end else begin
         if (wr_rl0) begin
            reload0_ff <= dat_i[CNT_W-1:0];
         end
         if (wr_rl1) begin
            reload1_ff <= dat_i[CNT_W-1:0];
         end
         if (wr_en) begin
            irq_en_ff <= dat_i[1:0];
         end
         if (wr_prio) begin
            prio_ff <= dat_i[1:0]; // R15
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt flags and requests
   // ---------------------------------------------------------------
   logic [1:0] flag_set, flag_clr;
   assign flag_set = {uf1, uf0}; // R14 R17
   assign flag_clr = wr_flag ? dat_i[1:0] : 2'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_ff <= 2'h0;
      end else begin
         flag_ff <= (flag_ff & ~flag_clr) | flag_set;
      end
   end

   assign timer0_irq_o = flag_ff[DPT_IRQ0_BIT] & irq_en_ff[DPT_IRQ0_BIT] &
                         (prio_ff != 2'h0); // R14
   assign timer1_irq_o = flag_ff[DPT_IRQ1_BIT] & irq_en_ff[DPT_IRQ1_BIT] &
                         (prio_ff != 2'h0); // R14
   assign irq_priority_o = prio_ff; // R15
   assign irq_vector_o = timer1_irq_o ? DPT_VEC_T1 : DPT_VEC_T0; // R16

   // ---------------------------------------------------------------
   // timer output and serial clock
   // ---------------------------------------------------------------
   logic divided_underflow_output_src;
   assign divided_underflow_output_src = (casc || ctrl_ff.output_channel_select) ? uf1 : uf0; // R19

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         divided_underflow_output_ff <= 1'b0;
      end else if (divided_underflow_output_src) begin
         divided_underflow_output_ff <= ~divided_underflow_output_ff; // R18
      end
   end

   assign divided_underflow_output_o = divided_underflow_output_ff;
   assign output_port_pin_o = ctrl_ff.output_enable ? divided_underflow_output_ff : 1'b1; // R20 R22
   assign serial_clock_tick_o = uf1; // R28

   // ---------------------------------------------------------------
   // read data and acknowledge
   // ---------------------------------------------------------------
   logic [31:0] rd;
   always_comb begin
      rd = 32'h0;
      if (adr_i == DPT_ADR_CTRL) begin
         rd[DPT_CTRL_W-1:0] = ctrl_ff;
      end else if (adr_i == DPT_ADR_T0CFG) begin
         rd[DPT_T0CFG_W-1:0] = t0cfg_ff;
      end else if (adr_i == DPT_ADR_T1CFG) begin
         rd[DPT_T1CFG_W-1:0] = {t1cfg_ff[DPT_T1CFG_W-1:1], run1};
      end else if (adr_i == DPT_ADR_RELOAD0) begin
         rd[CNT_W-1:0] = reload0_ff;
      end else if (adr_i == DPT_ADR_RELOAD1) begin
         rd[CNT_W-1:0] = reload1_ff;
      end else if (adr_i == DPT_ADR_COUNT) begin
         rd[2*CNT_W-1:0] = {cnt1_ff, cnt0_ff};
      end else if (adr_i == DPT_ADR_IRQ_FLAG) begin
         rd[1:0] = flag_ff;
      end else if (adr_i == DPT_ADR_IRQ_EN) begin
         rd[1:0] = irq_en_ff;
      end else if (adr_i == DPT_ADR_PRIO) begin
         rd[1:0] = prio_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0;
      end else begin
         ack_ff <= req;
         if (req && !we_i) begin
            dat_ff <= rd;
         end
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = dat_ff;
endmodule

// file: verification/dpt_event_source.sv
// event source model: free-running oscillators and a driven event pin
// assumes the bench calls drive just after a rising clock edge
module dpt_event_source (
   // system clock
   input wire logic clk_i,
   // oscillator and event pins
   output logic low_osc_o,
   output logic high_osc_o,
   output logic event_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      low_osc_o = 1'b0;
      high_osc_o = 1'b0;
      event_o = 1'b1;
      #20;
      fork
         forever #200 low_osc_o = ~low_osc_o;
         forever #150 high_osc_o = ~high_osc_o;
      join
   end
   // hold the pin at one level for whole clock cycles
   task automatic drive(input logic lvl, input int cycles);
      event_o <= lvl;
      repeat (cycles) @(posedge clk_i);
   endtask
endmodule

// file: verification/dpt_timer_monitor.sv
// checker for the dual programmable timer, bound to every dpt_timer instance
// assumes classic single-cycle wishbone requests on its bus port
module dpt_timer_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // interrupts, serial clock and output pin
   input wire logic timer0_irq_o,
   input wire logic timer1_irq_o,
   input wire logic [1:0] irq_priority_o,
   input wire logic [23:0] irq_vector_o,
   input wire logic serial_clock_tick_o,
   input wire logic divided_underflow_output_o,
   input wire logic output_port_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking mon_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   chk_ack_follow: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acknowledged after one cycle");
   chk_ack_single: assert property (ack_o |=> !ack_o)
      else $error("acknowledge longer than one cycle");
   chk_reset_state: assert property (disable iff (1'b0) rst_i |=> !ack_o && output_port_pin_o
      && !divided_underflow_output_o && !timer0_irq_o && !timer1_irq_o)
      else $error("outputs not idle after reset");
   chk_irq_prio: assert property (timer0_irq_o || timer1_irq_o |-> irq_priority_o != 2'h0)
      else $error("request raised at priority level zero");
   chk_vector_t1: assert property (timer1_irq_o |-> irq_vector_o == 24'h000006)
      else $error("wrong vector for timer 1 request");
   chk_vector_t0: assert property (!timer1_irq_o |-> irq_vector_o == 24'h000008)
      else $error("wrong vector without timer 1 request");
   chk_pin_gate: assert property (!output_port_pin_o |-> !divided_underflow_output_o)
      else $error("pin low while divided output high");
   chk_irq0_hold: assert property (timer0_irq_o && !(cyc_i && stb_i && we_i) |=> timer0_irq_o)
      else $error("timer 0 request dropped without a write");
   chk_irq1_hold: assert property (timer1_irq_o && !(cyc_i && stb_i && we_i) |=> timer1_irq_o)
      else $error("timer 1 request dropped without a write");
   chk_serial_gap: assert property (serial_clock_tick_o |=> !serial_clock_tick_o)
      else $error("serial tick longer than one cycle");
   chk_data_hold: assert property (!(ack_o && !we_i) |-> $stable(dat_o))
      else $error("read data changed without a read");
endmodule
bind dpt_timer dpt_timer_monitor u_dpt_timer_monitor (
   .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o, .timer0_irq_o, .timer1_irq_o,
   .irq_priority_o, .irq_vector_o, .serial_clock_tick_o, .divided_underflow_output_o,
   .output_port_pin_o
);

// file: verification/testbench.sv
// self-checking bench for the dual programmable timer over its wishbone port
// assumes the event source model makes both oscillators and the event pin
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import dpt_pkg::*;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, lo_osc, hi_osc, ev_pin;
   logic t0_irq, t1_irq, ser_tick, divided_underflow_output, pin;
   logic [1:0] prio;
   logic [23:0] vec;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o;
   logic [31:0] expq[$];
   logic [15:0] rnd;
   int failures, checks;
   dpt_timer #(.NR_DIV(2)) u_dpt_timer (
      .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .low_speed_oscillator_i(lo_osc), .high_speed_oscillator_i(hi_osc),
      .event_input_pin_i(ev_pin), .timer0_irq_o(t0_irq), .timer1_irq_o(t1_irq),
      .irq_priority_o(prio), .irq_vector_o(vec), .serial_clock_tick_o(ser_tick),
      .divided_underflow_output_o(divided_underflow_output), .output_port_pin_o(pin)
   );
   dpt_event_source u_dpt_event_source (
      .clk_i, .low_osc_o(lo_osc), .high_osc_o(hi_osc), .event_o(ev_pin)
   );
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d, failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic hung();
      failures++;
      $display("unexpected at %0t: wait ran out, got %h, expected %h", $time, 1'b0, 1'b1);
      complete_run();
   endtask
   // one classic cycle; on a read, d is the expected data
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      if (!w) begin
         expq.push_back(d);
      end
      @(posedge clk_i);
      while (ack_o !== 1'b1) begin
         @(posedge clk_i);
         n++;
         if (n > 20) hung();
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // cycles between two serial ticks, once the new setting has settled
   task automatic span(input int exp);
      int n;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         @(posedge clk_i);
         while (ser_tick !== 1'b1) begin
            @(posedge clk_i);
            n++;
            if (n > 600) hung();
         end
      end
      cmp(32'(n + 1), 32'(exp));
   endtask
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (ack_o === 1'b1 && we_i === 1'b0 && expq.size() > 0) begin
         cmp(dat_o, expq.pop_front());
      end
   end
   initial begin
      int n;
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'h1;
      dat_i = 32'h0;
      failures = 0;
      checks = 0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 10; i++) begin
         wb(1'b0, 8'(i * 4), 32'h0);
      end
      wb(1'b1, 8'h24, 32'hff);
      wb(1'b0, 8'h24, 32'h0);
      $display("test reset done");
      rnd = 16'hc7cf;
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         wb(1'b1, DPT_ADR_RELOAD0, {24'h0, rnd[7:0]});
         wb(1'b1, DPT_ADR_RELOAD1, {24'h0, rnd[15:8]});
         wb(1'b1, DPT_ADR_T0CFG, 32'h2);
         wb(1'b1, DPT_ADR_T1CFG, 32'h2);
         wb(1'b0, DPT_ADR_COUNT, {16'h0, rnd});
      end
      $display("test preset done");
      wb(1'b1, DPT_ADR_RELOAD1, 32'h0);
      for (int s = 0; s < 2; s++) begin
         for (int r = 0; r < 4; r++) begin
            wb(1'b1, DPT_ADR_CTRL, 32'(s << 1));
            wb(1'b1, DPT_ADR_T1CFG, 32'(r * 8 + 7));
            span((4 ** r) * (s == 1 ? 3 : 4));
         end
      end
      $display("test ratio done");
      wb(1'b1, DPT_ADR_RELOAD0, 32'h3);
      wb(1'b1, DPT_ADR_T1CFG, 32'h2);
      wb(1'b1, DPT_ADR_IRQ_FLAG, 32'h3);
      wb(1'b1, DPT_ADR_IRQ_EN, 32'h1);
      wb(1'b1, DPT_ADR_PRIO, 32'h2);
      wb(1'b1, DPT_ADR_T0CFG, 32'h3);
      n = 0;
      while (t0_irq !== 1'b1) begin
         @(posedge clk_i);
         n++;
         if (n > 200) hung();
      end
      cmp({30'h0, prio}, 32'h2);
      wb(1'b0, DPT_ADR_T0CFG, 32'h0);
      repeat (40) @(posedge clk_i);
      wb(1'b0, DPT_ADR_COUNT, 32'h3);
      wb(1'b1, DPT_ADR_IRQ_EN, 32'h0);
      wb(1'b0, DPT_ADR_IRQ_FLAG, 32'h1);
      cmp({31'h0, t0_irq}, 32'h0);
      wb(1'b1, DPT_ADR_IRQ_FLAG, 32'h1);
      wb(1'b0, DPT_ADR_IRQ_FLAG, 32'h0);
      $display("test one-shot done");
      for (int p = 0; p < 2; p++) begin
         wb(1'b1, DPT_ADR_RELOAD0, 32'h10);
         wb(1'b1, DPT_ADR_T0CFG, 32'(8'h9f | (p << 5)));
         for (int k = 0; k < 3; k++) begin
            u_dpt_event_source.drive(1'b0, 6);
            u_dpt_event_source.drive(1'b1, 6);
         end
         u_dpt_event_source.drive(1'b0, 6);
         wb(1'b0, DPT_ADR_COUNT, 32'(8'h0c + p));
         u_dpt_event_source.drive(1'b1, 6);
      end
      wb(1'b1, DPT_ADR_T0CFG, 32'hcd);
      u_dpt_event_source.drive(1'b1, 40);
      wb(1'b1, DPT_ADR_T0CFG, 32'hcf);
      u_dpt_event_source.drive(1'b0, 3);
      u_dpt_event_source.drive(1'b1, 40);
      u_dpt_event_source.drive(1'b0, 40);
      u_dpt_event_source.drive(1'b1, 40);
      wb(1'b0, DPT_ADR_COUNT, 32'h0f);
      $display("test event done");
      u_dpt_event_source.drive(1'b0, 4);
      wb(1'b1, DPT_ADR_RELOAD0, 32'hff);
      wb(1'b1, DPT_ADR_T0CFG, 32'h67);
      u_dpt_event_source.drive(1'b0, 40);
      wb(1'b0, DPT_ADR_COUNT, 32'hff);
      u_dpt_event_source.drive(1'b1, 40);
      u_dpt_event_source.drive(1'b0, 8);
      wb(1'b0, DPT_ADR_COUNT, 32'hf5);
      $display("test width done");
      wb(1'b1, DPT_ADR_RELOAD0, 32'h1);
      wb(1'b1, DPT_ADR_CTRL, 32'h16);
      wb(1'b1, DPT_ADR_T1CFG, 32'h1d);
      wb(1'b1, DPT_ADR_T0CFG, 32'h0f);
      wb(1'b1, DPT_ADR_IRQ_FLAG, 32'h3);
      wb(1'b1, DPT_ADR_IRQ_EN, 32'h3);
      wb(1'b1, DPT_ADR_PRIO, 32'h3);
      n = int'(divided_underflow_output ^ ser_tick);
      span(32);
      @(posedge clk_i);
      cmp(32'(divided_underflow_output), 32'(n ^ 1));
      wb(1'b0, DPT_ADR_IRQ_FLAG, 32'h2);
      cmp({31'h0, t1_irq}, 32'h1);
      cmp({8'h0, vec}, 32'h6);
      cmp(32'(pin), 32'(n ^ 1));
      wb(1'b1, DPT_ADR_CTRL, 32'h12);
      cmp({31'h0, pin}, 32'h1);
      $display("test cascade done");
      complete_run();
   end
endmodule
